// *** include/ecph_map.svh ***
/*
 * constants of the host-side handshake port: mode codes, timing figures
 * and cycle counts. assumes a 10 MHz ref_clk.
 */
// Summary of operation
// - In FIFO forward mode the next byte starts on the busy line alone and the acknowledge line is ignored.
// - FIFO forward mode can keep up near 500 Kbps when fed steadily.
// - In forward idle the host keeps its strobe high while the peripheral keeps its handshake low.
// - Forward transfers start only from forward idle.
// - The host drops its strobe only after the peripheral has dropped its handshake line; in FIFO mode the code may drop it while busy is still high.
// - Data is stable for a setup interval before the host strobe falls.
// - In enhanced mode, after the strobe falls the peripheral raises its handshake and the host then raises its strobe; in FIFO mode the host does not wait for it.
// - In reverse idle the peripheral strobe is high and the host handshake is low.
// - Reverse transfers start only from reverse idle, with the host handshake low after each byte.
// - The host raises its handshake, the peripheral raises its strobe, and the host drops its handshake after capture.
// - The host handshake changes 80 to 200 ns after each peripheral strobe edge; the code takes 300 to 400 ns, longer while stalled.
// - The host stalls reverse transfers by holding its handshake low when it has no room.
// - Entering the enhanced mode switches critical outputs from open-collector to totem-pole without glitches.
`ifndef ECPH_MAP_SVH
`define ECPH_MAP_SVH

`define ECPH_MODE_W        3
`define ECPH_MODE_COMPAT   3'h0
`define ECPH_MODE_FIFO     3'h5
`define ECPH_MODE_ENH      3'h3
`define ECPH_CLK_NS        100
`define ECPH_SETUP_NS      200
`define ECPH_SETUP_CYC     ((`ECPH_SETUP_NS + `ECPH_CLK_NS - 1) / `ECPH_CLK_NS)
`define ECPH_ACK_MIN_NS    80
`define ECPH_ACK_MAX_NS    200
`define ECPH_ACK_MIN_CYC   ((`ECPH_ACK_MIN_NS + `ECPH_CLK_NS - 1) / `ECPH_CLK_NS)
`define ECPH_FIFO_BIT_KBPS 500

`endif

// *** include/ecph_pkg.sv ***
/*
 * types of the host-side handshake port.
 * assumes ecph_map.svh is on the include path.
 */
package ecph_pkg;
	typedef enum logic [2:0] {
		ECPH_FWD_IDLE  = 3'b000,
		ECPH_FWD_SETUP = 3'b001,
		ECPH_FWD_LOW   = 3'b010,
		ECPH_FWD_HIGH  = 3'b011,
		ECPH_REV_IDLE  = 3'b100,
		ECPH_REV_WAIT  = 3'b101,
		ECPH_REV_ACK   = 3'b110
	} ecph_state_e;
	typedef logic [7:0] ecph_byte_t;
endpackage

// *** rtl/ecph_port.sv ***
/*
 * host end of the enhanced parallel handshake: forward and reverse byte
 * transfers, fifo-mode forward pacing and the open-collector/totem-pole
 * driver switch. assumes the peripheral lines are synchronous-capable
 * inputs and the board resolves pins from the output enables.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ecph_map.svh"

module ecph_port #(
	parameter int SETUP_CYC = `ECPH_SETUP_CYC,
	parameter int ACK_CYC   = `ECPH_ACK_MIN_CYC
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              resetn,
	// mode and direction
	input  wire logic [2:0]        mode,
	input  wire logic              reverse_dir,
	// user forward byte stream
	input  wire logic              tx_valid,
	output logic                   tx_ready,
	input  wire ecph_pkg::ecph_byte_t tx_data,
	// user reverse byte stream
	output logic                   rx_valid,
	input  wire logic              rx_ready,
	output ecph_pkg::ecph_byte_t   rx_data,
	output logic                   reverse_request,
	// data pins
	input  wire logic [7:0]        data_in,
	output logic [7:0]             data_out,
	output logic [7:0]             data_oe,
	// host strobe pin
	input  wire logic              strobe_pin_in,
	output logic                   strobe_pin_out,
	output logic                   strobe_pin_oe,
	// host handshake pin
	input  wire logic              autofeed_pin_in,
	output logic                   autofeed_pin_out,
	output logic                   autofeed_pin_oe,
	// peripheral lines
	input  wire logic              peripheral_handshake_line,
	input  wire logic              acknowledge_pin,
	input  wire logic              fault_pin
);
	import ecph_pkg::*;

	ecph_state_e state;
	ecph_state_e next_state;
	logic [2:0]  busy_sync;
	logic [2:0]  ack_sync;
	logic [1:0]  fault_sync;
	logic [7:0]  cnt;
	logic        host_strobe_line;
	logic        host_handshake_line;
	logic        totem;
	ecph_byte_t  tx_hold;

	// first stage feeds only the second; the third holds the previous value
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			busy_sync  <= 3'h0;
			ack_sync   <= 3'h7;
			fault_sync <= 2'h3;
		end else begin
			busy_sync  <= {busy_sync[1:0], peripheral_handshake_line};
			ack_sync   <= {ack_sync[1:0], acknowledge_pin};
			fault_sync <= {fault_sync[0], fault_pin};
		end
	end

	wire busy       = busy_sync[1];
	wire peripheral_strobe_line = ack_sync[1];
	wire strobe_rise = ack_sync[1] & ~ack_sync[2];
	wire strobe_fall = ~ack_sync[1] & ack_sync[2];
	wire fifo_mode  = (mode == `ECPH_MODE_FIFO);
	wire enh_mode   = (mode == `ECPH_MODE_ENH);
	wire cnt_done   = (cnt == 8'h00);
	wire rx_room    = ~rx_valid | rx_ready;
	// fifo mode never looks at the peripheral acknowledge line
	wire fwd_go     = tx_valid & ~busy;
	wire fwd_take   = fifo_mode ? ~busy : busy;

	always_comb begin
		next_state = state;
		unique case (state)
			ECPH_FWD_IDLE:
				if (reverse_dir && enh_mode)
					next_state = ECPH_REV_IDLE;
				else if (fwd_go && (fifo_mode || enh_mode))
					next_state = ECPH_FWD_SETUP;
			ECPH_FWD_SETUP:
				if (cnt_done)
					next_state = ECPH_FWD_LOW;
			ECPH_FWD_LOW:
				if (fwd_take)
					next_state = ECPH_FWD_HIGH;
			ECPH_FWD_HIGH:
				if (fifo_mode || !busy)
					next_state = ECPH_FWD_IDLE;
			ECPH_REV_IDLE:
				if (!reverse_dir)
					next_state = ECPH_FWD_IDLE;
				else if (strobe_fall)
					next_state = ECPH_REV_WAIT;
			ECPH_REV_WAIT:
				if (cnt_done && rx_room)
					next_state = ECPH_REV_ACK;
			ECPH_REV_ACK:
				if (cnt_done && peripheral_strobe_line && !strobe_rise)
					next_state = ECPH_REV_IDLE;
			default:
				next_state = ECPH_FWD_IDLE;
		endcase
	end

	// delay counter reloads on entry to the setup state and on each strobe edge
	wire [7:0] next_cnt =
		(state == ECPH_FWD_IDLE && next_state == ECPH_FWD_SETUP) ? 8'(SETUP_CYC - 1) :
		(strobe_fall || strobe_rise) ? 8'(ACK_CYC - 1) :
		cnt_done ? 8'h00 : cnt - 8'h01;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state <= ECPH_FWD_IDLE;
			cnt   <= 8'h00;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
		end
	end

	// latch the byte when accepted so data stays stable through the strobe
	assign tx_ready = (state == ECPH_FWD_IDLE) & fwd_go & (fifo_mode | enh_mode) & ~reverse_dir;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			tx_hold <= 8'h00;
		else if (tx_ready)
			tx_hold <= tx_data;
	end

	// capture on the peripheral strobe fall; setup is the peripheral's duty
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rx_valid <= 1'b0;
			rx_data  <= 8'h00;
		end else if (state == ECPH_REV_IDLE && next_state == ECPH_REV_WAIT) begin
			rx_valid <= 1'b1;
			rx_data  <= data_in;
		end else if (rx_ready) begin
			rx_valid <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			host_strobe_line    <= 1'b1;
			host_handshake_line <= 1'b0;
			reverse_request     <= 1'b0;
		end else begin
			// strobe high in idle, low only for the low phase
			host_strobe_line    <= (next_state != ECPH_FWD_LOW);
			// handshake high only while acknowledging; low stalls the peripheral
			host_handshake_line <= (next_state == ECPH_REV_ACK);
			// fault line is low-true; tolerated at any time, only reported
			reverse_request     <= ~fault_sync[1];
		end
	end

	// driver mode changes only while the strobe rests high, so no pin glitches
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			totem <= 1'b0;
		else if (host_strobe_line && (state == ECPH_FWD_IDLE))
			totem <= enh_mode | fifo_mode;
	end

	wire rev_side = (state == ECPH_REV_IDLE) | (state == ECPH_REV_WAIT) |
		(state == ECPH_REV_ACK);

	// open-collector drives only low; totem-pole drives both levels
	assign data_out         = tx_hold;
	assign data_oe          = rev_side ? 8'h00 : (totem ? 8'hff : ~tx_hold);
	assign strobe_pin_out   = host_strobe_line;
	assign strobe_pin_oe    = totem | ~host_strobe_line;
	assign autofeed_pin_out = host_handshake_line;
	assign autofeed_pin_oe  = totem | ~host_handshake_line;

	wire unused_ok = strobe_pin_in ^ autofeed_pin_in;
endmodule // ecph_port

`default_nettype wire

// *** dv/ecph_port_checker.sv ***
/* pin-level assertions for the host handshake port.
 assumes the bind below into ecph_port. */
`timescale 1ns/10ps
`default_nettype none
module ecph_port_checker #(parameter int SETUP_CYC = 2) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [2:0] mode,
	input wire logic reverse_dir,
	input wire logic tx_ready,
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire logic reverse_request,
	input wire logic [7:0] data_out,
	input wire logic strobe_pin_out,
	input wire logic autofeed_pin_out,
	input wire logic peripheral_handshake_line,
	input wire logic acknowledge_pin,
	input wire logic fault_pin
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// busy has to survive two sync flops before the strobe may return
	sequence busy_seen;
		!strobe_pin_out && mode == 3'h3 ##0 peripheral_handshake_line [*3];
	endsequence
	setup_hold_a: assert property ($fell(strobe_pin_out) |-> $past(data_out, SETUP_CYC) == data_out)
		else $error("data moved inside setup");
	strobe_start_a: assert property ($fell(strobe_pin_out) |-> !peripheral_handshake_line)
		else $error("strobe fell while busy");
	strobe_return_a: assert property (busy_seen |-> ##[1:2] strobe_pin_out)
		else $error("strobe not returned");
	strobe_keep_a: assert property ($rose(strobe_pin_out) && mode == 3'h3 |-> $past(peripheral_handshake_line))
		else $error("strobe rose without busy");
	fwd_entry_a: assert property (tx_ready |-> strobe_pin_out && mode != 3'h0 && !reverse_dir)
		else $error("byte taken outside idle");
	hs_rise_a: assert property ($rose(autofeed_pin_out) |-> $past(acknowledge_pin) == 1'b0)
		else $error("handshake rose early");
	hs_fall_a: assert property ($rose(acknowledge_pin) && autofeed_pin_out |-> ##[1:4] !autofeed_pin_out)
		else $error("handshake not dropped");
	rev_idle_a: assert property (reverse_dir && acknowledge_pin [*5] |-> !autofeed_pin_out)
		else $error("handshake high in idle");
	rev_stall_a: assert property (rx_valid && !rx_ready |=> !$rose(autofeed_pin_out))
		else $error("no stall without room");
	fault_req_a: assert property (!fault_pin [*4] |-> reverse_request)
		else $error("reverse request missed");
endmodule // ecph_port_checker
bind ecph_port ecph_port_checker #(.SETUP_CYC(SETUP_CYC)) ecph_port_checker_inst (.ref_clk, .resetn,
	.mode, .reverse_dir, .tx_ready, .rx_valid, .rx_ready, .reverse_request, .data_out,
	.strobe_pin_out, .autofeed_pin_out, .peripheral_handshake_line, .acknowledge_pin, .fault_pin);
`default_nettype wire

// *** dv/ecph_periph.sv ***
/* peripheral across the cable: takes forward bytes after a lag and
 sends reverse bytes on request. assumes pulled-up data lines. */
`timescale 1ns/10ps
`default_nettype none
module ecph_periph (
	input wire logic ref_clk,
	input wire logic host_strobe,
	input wire logic host_hs,
	input wire logic [7:0] pins,
	input wire logic [2:0] lag,
	output logic busy,
	output logic pstb,
	output logic [7:0] drive,
	output logic [7:0] got,
	output int n_got
);
	initial begin
		busy = 1'b0;
		pstb = 1'b1;
		drive = 8'hff;
		got = 8'h00;
		n_got = 0;
	end
	always @(negedge host_strobe) begin
		repeat (lag + 1) @(posedge ref_clk);
		busy <= 1'b1;
		// a short fifo-mode strobe may already be back high by now
		if (host_strobe !== 1'b1)
			@(posedge host_strobe);
		@(posedge ref_clk);
		got <= pins;
		n_got <= n_got + 1;
		repeat (lag) @(posedge ref_clk);
		busy <= 1'b0;
	end
	task automatic send(input logic [7:0] b);
		@(posedge ref_clk);
		drive <= b;
		repeat (lag + 1) @(posedge ref_clk);
		pstb <= 1'b0;
		wait (host_hs);
		@(posedge ref_clk);
		pstb <= 1'b1;
		wait (!host_hs);
		@(posedge ref_clk);
		drive <= 8'hff;
	endtask
endmodule // ecph_periph
`default_nettype wire

// *** dv/ecph_port_tb_top.sv ***
/* self-checking bench: random forward and reverse bytes through the
 peripheral model. assumes the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module ecph_port_tb_top;
	import ecph_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [2:0] mode = 3'h0;
	logic [2:0] lag = 3'h0;
	logic reverse_dir = 1'b0;
	logic tx_valid = 1'b0;
	logic rx_ready = 1'b0;
	logic fault_pin = 1'b1;
	ecph_byte_t tx_data = 8'h00;
	ecph_byte_t q[$];
	int n_mismatch = 0;
	int n_compared = 0;
	int n_got;
	wire logic tx_ready, rx_valid, reverse_request, busy, pstb;
	wire logic strobe_pin_out, strobe_pin_oe, autofeed_pin_out, autofeed_pin_oe;
	wire logic [7:0] rx_data, data_out, data_oe, drive, got;
	// undriven lines float high through the cable pull-ups
	wire logic [7:0] pins = (data_out | ~data_oe) & drive;
	wire logic hstb = strobe_pin_out | ~strobe_pin_oe;
	wire logic hhs = autofeed_pin_out | ~autofeed_pin_oe;
	ecph_port #(.SETUP_CYC(2), .ACK_CYC(1)) ecph_port_inst (.ref_clk, .resetn, .mode,
		.reverse_dir, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data,
		.reverse_request, .data_in(pins), .data_out, .data_oe, .strobe_pin_in(hstb),
		.strobe_pin_out, .strobe_pin_oe, .autofeed_pin_in(hhs), .autofeed_pin_out,
		.autofeed_pin_oe, .peripheral_handshake_line(busy), .acknowledge_pin(pstb), .fault_pin);
	ecph_periph ecph_periph_inst (.ref_clk, .host_strobe(hstb), .host_hs(hhs), .pins, .lag,
		.busy, .pstb, .drive, .got, .n_got);
	always #50 ref_clk = ~ref_clk;
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task fwd(input ecph_byte_t b);
		int c;
		c = n_got;
		tx_data <= b;
		tx_valid <= 1'b1;
		do @(posedge ref_clk); while (tx_ready !== 1'b1);
		tx_valid <= 1'b0;
		for (int i = 0; i < 80 && n_got == c; i++) @(posedge ref_clk);
		chk(got, b);
	endtask
	// random room on the receive side exercises the stall path
	always @(posedge ref_clk) begin
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
			chk(rx_data, q.size() > 0 ? q.pop_front() : 8'hxx);
		rx_ready <= ($urandom % 3) != 0;
	end
	initial begin
		void'($urandom(32'h084d));
		repeat (12) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		tx_valid <= 1'b1;
		repeat (6) @(posedge ref_clk) chk({7'h0, tx_ready}, 8'h00);
		$display("compat refusal done");
		for (int m = 0; m < 2; m++) begin
			mode <= m ? 3'h3 : 3'h5;
			for (int i = 0; i < 12; i++) begin
				lag <= 3'(i);
				fwd(i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($urandom));
			end
			$display("forward mode %0d done", m);
		end
		fault_pin <= 1'b0;
		repeat (5) @(posedge ref_clk);
		chk({7'h0, reverse_request}, 8'h01);
		fault_pin <= 1'b1;
		reverse_dir <= 1'b1;
		repeat (4) @(posedge ref_clk);
		for (int i = 0; i < 10; i++) begin
			lag <= 3'($urandom);
			q.push_back(8'($urandom));
			ecph_periph_inst.send(q[$]);
		end
		for (int i = 0; i < 50 && q.size() > 0; i++) @(posedge ref_clk);
		chk(8'(q.size()), 8'h00);
		chk({7'h0, autofeed_pin_out}, 8'h00);
		$display("reverse done");
		tally_and_finish;
	end
	initial begin
		#3000000;
		n_mismatch++;
		tally_and_finish;
	end
endmodule // ecph_port_tb_top
`default_nettype wire
